// *** fes_bus.sv ***
`timescale 1ns/1ps
`default_nettype none
module fes_bus
  import fes_pkg::*;
(
  input  wire logic      mclk_i,
  input  wire logic      rst_n_i,
  input  wire logic      abort_i,
  input  wire logic      start_i,
  input  wire fes_cyc_t  cyc_i,
  input  wire logic [DW-1:0] dq_i,
  output fes_pins_t      pins_o,
  output logic           done_o,
  output logic [DW-1:0]  rdata_o
);

  typedef enum logic [1:0] {B_IDLE, B_SET, B_PULSE, B_HOLD} fes_ph_t;

  typedef struct packed {
    fes_ph_t         ph;
    logic [3:0]      cnt;
    logic            wr;
    fes_pins_t       pins;
    logic            done;
    logic [DW-1:0]   rdata;
  } fes_bus_st_t;

  fes_bus_st_t s;
  fes_bus_st_t next_s;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    case (s.ph)
      B_IDLE: begin
        if (start_i) begin
          next_s.wr = cyc_i.wr;
          next_s.pins.addr = cyc_i.addr;
          next_s.pins.dq = cyc_i.data;
          next_s.pins.dq_oe_n = ~cyc_i.wr;
          next_s.pins.ce_n = 1'b0;
          next_s.ph = B_SET;
        end
      end
      B_SET: begin
        next_s.pins.we_n = ~s.wr;
        next_s.pins.oe_n = s.wr;
        next_s.cnt = s.wr ? WP_CYC - 4'h1 : ACC_CYC - 4'h1;
        next_s.ph = B_PULSE;
      end
      B_PULSE: begin
        if (s.cnt == 4'h0) begin
          // Write data is latched by the device on this rising edge.
          next_s.pins.we_n = 1'b1;
          next_s.pins.oe_n = 1'b1;
          if (!s.wr) begin
            next_s.rdata = dq_i;
          end
          next_s.ph = B_HOLD;
        end else begin
          next_s.cnt = s.cnt - 4'h1;
        end
      end
      B_HOLD: begin
        next_s.pins.ce_n = 1'b1;
        next_s.pins.dq_oe_n = 1'b1;
        next_s.done = 1'b1;
        next_s.ph = B_IDLE;
      end
      default: next_s.ph = B_IDLE;
    endcase
    if (abort_i) begin
      next_s.ph = B_IDLE;
      next_s.pins.we_n = 1'b1;
      next_s.pins.oe_n = 1'b1;
      next_s.pins.ce_n = 1'b1;
      next_s.pins.dq_oe_n = 1'b1;
      next_s.done = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
      s.pins.we_n <= 1'b1;
      s.pins.oe_n <= 1'b1;
      s.pins.ce_n <= 1'b1;
      s.pins.dq_oe_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign pins_o  = s.pins;
  assign done_o  = s.done;
  assign rdata_o = s.rdata;

endmodule
`default_nettype wire

// *** fes_flash_mdl.sv ***
`timescale 1ns/1ps
`default_nettype none
module fes_flash_mdl
  import fes_pkg::*;
(
  input  wire logic      mclk_i,
  input  wire logic      rst_n_i,
  input  wire fes_pins_t pins_i,
  output logic [DW-1:0]  dq_o,
  output logic           ready_busy_n_o
);
  localparam logic [11:0] ERA = 12'h12c;
  localparam logic [11:0] WIN = 12'(WIN_CYC);
  typedef enum logic [2:0] {M_RD, M_CHIP, M_WIN, M_SECT, M_SUS, M_PWW, M_PWP, M_PWV} fes_mm_t;
  fes_mm_t       m = M_RD;
  logic [DW-1:0] h [6] = '{default: '0};
  // Power-up state only; a hardware reset keeps the password and the erased marks.
  logic [DW-1:0] pw [4] = '{default: 16'hffff};
  logic [255:0]  sel = '0, ers = '0;
  logic [11:0]   t = '0, rem = '0;
  logic [1:0]    bk = '0;
  logic          pwe = 1'b1, pre = 1'b1, tog = 1'b0;
  logic [DW-1:0] rd, last = '0;
  int            nw = 0;
  wire [AW-1:0]  a = pins_i.addr;
  wire [DW-1:0]  d = pins_i.dq;
  wire [7:0]     sec = a[22:15];
  wire           un = h[4] == UNL1_DATA && h[5] == UNL2_DATA;
  wire           un5 = un && h[1] == UNL1_DATA && h[2] == UNL2_DATA && h[3] == SETUP_CODE;
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      m   <= M_RD;
      t   <= '0;
      sel <= '0;
    end else begin
      pwe  <= pins_i.we_n;
      pre  <= pins_i.oe_n;
      last <= dq_o;
      if (pre && !pins_i.oe_n) tog <= !tog;
      if (t != 0) t <= t - 12'h001;
      if (t == 1 && m == M_WIN) begin
        m <= M_SECT;
        t <= ERA;
      end
      if (t == 1 && (m == M_CHIP || m == M_SECT)) begin
        // The busy time stands for preprogramming and erasure together.
        m   <= M_RD;
        ers <= ers | (m == M_CHIP ? '1 : sel);
        sel <= '0;
      end
      if (!pwe && pins_i.we_n) begin
        nw <= nw + 1;
        h  <= '{h[1], h[2], h[3], h[4], h[5], d};
        case (m)
          M_CHIP: ;
          M_SECT: if (d == SUSP_CODE) begin
            m   <= M_SUS;
            rem <= t;
          end
          M_WIN: if (d == SECT_CODE) begin
            sel[sec] <= 1'b1;
            t        <= WIN;
          end else if (d == SUSP_CODE) begin
            m   <= M_SUS;
            rem <= ERA;
          end else begin
            m   <= M_RD;
            sel <= '0;
          end
          M_SUS: if (d == RESUME_CODE) begin
            m <= M_SECT;
            t <= rem;
          end
          M_PWW: begin
            pw[a[1:0]] <= pw[a[1:0]] & d;
            m          <= M_PWP;
            t          <= 12'h028;
          end
          default: if (d == RESET_CODE) m <= M_RD;
          else if (un && d == PW_PROG_CODE) m <= M_PWW;
          else if (un && d == PW_VER_CODE) m <= M_PWV;
          else if (un5 && d == CHIP_CODE) begin
            m <= M_CHIP;
            t <= ERA;
          end else if (un5 && d == SECT_CODE) begin
            m        <= M_WIN;
            t        <= WIN;
            bk       <= a[22:21];
            sel[sec] <= 1'b1;
          end
        endcase
      end
    end
  end
  always_comb begin
    rd = ers[sec] ? 16'hffff : (a[15:0] ^ 16'h3c3c);
    if (m == M_PWV) rd = pw[a[1:0]];
    else if (m == M_PWW || m == M_PWP) rd = {8'h00, t == 0, tog && t != 0, 6'h00};
    else if (m == M_CHIP || ((m == M_WIN || m == M_SECT) && a[22:21] == bk))
      rd = {8'h00, 1'b0, tog, 2'b00, m != M_WIN, tog, 2'b00};
    else if (m == M_SUS && sel[sec]) rd = {8'h00, 1'b1, 4'h0, tog, 2'b00};
  end
  // An undriven bus shows a changing pattern so stale data cannot pass for a read.
  assign dq_o = !pins_i.dq_oe_n ? pins_i.dq : (!pins_i.ce_n && !pins_i.oe_n) ? rd : ~last;
  assign ready_busy_n_o = !(m == M_CHIP || m == M_SECT || (m == M_PWP && t != 0));
endmodule
`default_nettype wire

// *** fes_host_seq.sv ***
`timescale 1ns/1ps
`default_nettype none
module fes_host_seq
  import fes_pkg::*;
(
  input  wire logic          mclk_i,
  input  wire logic          rst_n_i,
  input  wire logic          cmd_valid_i,
  input  wire fes_op_t       cmd_op_i,
  input  wire logic [AW-1:0] cmd_addr_i,
  input  wire logic [DW-1:0] cmd_data_i,
  input  wire logic          hw_reset_i,
  input  wire logic [DW-1:0] fl_dq_i,
  input  wire logic          fl_ready_busy_n_i,
  output fes_pins_t          fl_o,
  output logic               fl_reset_n_o,
  output logic               cmd_ready_o,
  output logic               cmd_done_o,
  output logic               cmd_refused_o,
  output logic [DW-1:0]      rdata_o,
  output logic [DW-1:0]      status_o,
  output logic               dev_ready_o,
  output logic               window_open_o,
  output logic               suspended_o,
  output logic               erase_aborted_o,
  output logic [3:0]         pw_portions_o
);

  typedef enum logic [3:0] {
    S_IDLE, S_ISSUE, S_WAIT, S_POLL_REQ, S_POLL_WAIT,
    S_WINDOW, S_SUSPW, S_SUSP, S_HWRST
  } fes_st_t;

  typedef struct packed {
    fes_st_t         st;
    fes_op_t         op;
    logic [2:0]      step;
    logic [AW-1:0]   addr;
    logic [DW-1:0]   data;
    logic            bus_start;
    fes_cyc_t        cyc;
    logic            tog;
    logic            have;
    logic [11:0]     cnt;
    logic            sect;
    logic            susp;
    logic            aborted;
    logic [3:0]      pw_done;
    logic            rdy;
    logic            done;
    logic            refused;
    logic [DW-1:0]   rdata;
    logic [DW-1:0]   status;
    logic [DW-1:0]   dq_s1;
    logic [DW-1:0]   dq_s2;
    logic            rb_s1;
    logic            rb_s2;
    logic            rst_pin;
    logic            win;
  } fes_main_t;

  fes_main_t     s;
  fes_main_t     next_s;
  logic          rs1;
  logic          rst_n;
  logic          acc;
  logic          bus_done;
  logic [DW-1:0] bus_rdata;
  logic [2:0]    wr_cnt;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rs1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1 <= 1'b1;
      rst_n <= rs1;
    end
  end

  function automatic logic [2:0] last_step(input fes_op_t op);
    case (op)
      OP_CHIP, OP_SECT:    last_step = LAST_LONG;
      OP_PWPROG, OP_PWVER: last_step = LAST_PW;
      default:             last_step = LAST_ONE;
    endcase
  endfunction

  function automatic fes_cyc_t seq_cyc(input fes_op_t op, input logic [2:0] step,
                                       input logic [AW-1:0] a, input logic [DW-1:0] d);
    seq_cyc = '{wr: 1'b1, addr: a, data: d};
    if (op == OP_CHIP || op == OP_SECT || op == OP_PWPROG || op == OP_PWVER) begin
      case (step)
        3'h0, 3'h3: seq_cyc = '{wr: 1'b1, addr: UNL1_ADDR, data: UNL1_DATA};
        3'h1, 3'h4: seq_cyc = '{wr: 1'b1, addr: UNL2_ADDR, data: UNL2_DATA};
        default:    seq_cyc = '{wr: 1'b1, addr: UNL1_ADDR, data: SETUP_CODE};
      endcase
      if (op == OP_PWPROG && step == 3'h2) begin
        seq_cyc.data = PW_PROG_CODE;
      end
      if (op == OP_PWVER && step == 3'h2) begin
        seq_cyc.data = PW_VER_CODE;
      end
      if (step == last_step(op)) begin
        case (op)
          OP_CHIP:  seq_cyc = '{wr: 1'b1, addr: UNL1_ADDR, data: CHIP_CODE};
          OP_SECT:  seq_cyc = '{wr: 1'b1, addr: a, data: SECT_CODE};
          OP_PWVER: seq_cyc = '{wr: 1'b0, addr: a, data: d};
          default:  seq_cyc = '{wr: 1'b1, addr: a, data: d};
        endcase
      end
    end else begin
      case (op)
        OP_ADD:    seq_cyc.data = SECT_CODE;
        OP_SUSP:   seq_cyc.data = SUSP_CODE;
        OP_RESUME: seq_cyc.data = RESUME_CODE;
        OP_RESET:  seq_cyc.data = RESET_CODE;
        default:   seq_cyc.wr = 1'b0;
      endcase
    end
  endfunction

  // Commands that would cancel a pending sector erase are refused here.
  function automatic logic op_legal(input fes_main_t st, input fes_op_t op);
    case (st.st)
      S_IDLE:     op_legal = !(op inside {OP_ADD, OP_SUSP, OP_RESUME});
      S_WINDOW:   op_legal = (op == OP_ADD && st.cnt < WIN_LIM) || op == OP_SUSP;
      S_POLL_REQ: op_legal = op == OP_SUSP && st.sect;
      S_SUSP:     op_legal = op inside {OP_READ, OP_RESUME, OP_RESET};
      default:    op_legal = 1'b0;
    endcase
  endfunction

  always_comb begin
    next_s = s;
    acc = 1'b0;
    next_s.bus_start = 1'b0;
    next_s.done = 1'b0;
    next_s.refused = 1'b0;
    next_s.dq_s1 = fl_dq_i;
    next_s.dq_s2 = s.dq_s1;
    next_s.rb_s1 = fl_ready_busy_n_i;
    next_s.rb_s2 = s.rb_s1;
    if (s.rdy && cmd_valid_i) begin
      if (op_legal(s, cmd_op_i)) begin
        acc = 1'b1;
        next_s.op = cmd_op_i;
        next_s.addr = cmd_addr_i;
        next_s.data = cmd_data_i;
        next_s.step = 3'h0;
        next_s.st = S_ISSUE;
        if (cmd_op_i == OP_CHIP || cmd_op_i == OP_SECT) begin
          next_s.aborted = 1'b0;
        end
      end else begin
        next_s.refused = 1'b1;
      end
    end
    if (!acc) begin
      case (s.st)
        S_ISSUE: begin
          next_s.bus_start = 1'b1;
          next_s.cyc = seq_cyc(s.op, s.step, s.addr, s.data);
          next_s.st = S_WAIT;
        end
        S_WAIT: begin
          if (bus_done) begin
            if (s.step != last_step(s.op)) begin
              next_s.step = s.step + 3'h1;
              next_s.st = S_ISSUE;
            end else begin
              next_s.have = 1'b0;
              next_s.cnt = 12'h000;
              case (s.op)
                OP_CHIP: next_s.st = S_POLL_REQ;
                OP_SECT, OP_ADD: begin
                  next_s.sect = 1'b1;
                  next_s.st = S_WINDOW;
                end
                OP_SUSP: next_s.st = S_SUSPW;
                OP_RESUME: begin
                  next_s.susp = 1'b0;
                  next_s.st = S_POLL_REQ;
                end
                OP_PWPROG: begin
                  next_s.pw_done[s.addr[1:0]] = 1'b1;
                  next_s.st = S_POLL_REQ;
                end
                default: begin
                  next_s.rdata = bus_rdata;
                  next_s.done = 1'b1;
                  next_s.st = s.susp ? S_SUSP : S_IDLE;
                end
              endcase
            end
          end
        end
        S_POLL_REQ: begin
          next_s.bus_start = 1'b1;
          next_s.cyc = '{wr: 1'b0, addr: s.addr, data: s.data};
          next_s.st = S_POLL_WAIT;
        end
        S_POLL_WAIT: begin
          if (bus_done) begin
            next_s.status = bus_rdata;
            next_s.tog = bus_rdata[TOG_BIT];
            next_s.have = 1'b1;
            next_s.st = S_POLL_REQ;
            // Two reads with a steady toggle bit mean the operation is over; only a password write leaves the bank out of read mode.
            if (s.have && bus_rdata[TOG_BIT] == s.tog) begin
              next_s.sect = 1'b0;
              if (s.op == OP_PWPROG) begin
                // A reset command is needed before the device serves reads again.
                next_s.op = OP_RESET;
                next_s.step = 3'h0;
                next_s.st = S_ISSUE;
              end else begin
                next_s.done = 1'b1;
                next_s.st = S_IDLE;
              end
            end
          end
        end
        S_WINDOW: begin
          next_s.cnt = s.cnt + 12'h001;
          if (s.cnt >= WIN_LIM) begin
            next_s.have = 1'b0;
            next_s.st = S_POLL_REQ;
          end
        end
        S_SUSPW: begin
          next_s.cnt = s.cnt + 12'h001;
          if (s.cnt == SUSP_CYC - 12'h001) begin
            next_s.susp = 1'b1;
            next_s.done = 1'b1;
            next_s.st = S_SUSP;
          end
        end
        S_HWRST: begin
          next_s.cnt = s.cnt + 12'h001;
          if (s.cnt == RP_CYC - 12'h001) begin
            next_s.rst_pin = 1'b1;
            next_s.st = S_IDLE;
          end
        end
        default: ;
      endcase
    end
    if (hw_reset_i) begin
      // An operation cut short leaves the flag up until an erase is reissued.
      // A command taken in this same cycle is cut too, so the set wins over its clear.
      if ((s.st != S_IDLE && s.st != S_HWRST) || acc) begin
        next_s.aborted = 1'b1;
      end
      next_s.st = S_HWRST;
      next_s.cnt = 12'h000;
      next_s.rst_pin = 1'b0;
      next_s.sect = 1'b0;
      next_s.susp = 1'b0;
      next_s.bus_start = 1'b0;
      next_s.done = 1'b0;
    end
    next_s.rdy = !hw_reset_i && (next_s.st inside {S_IDLE, S_WINDOW, S_SUSP}
                 || (next_s.st == S_POLL_REQ && next_s.sect));
    next_s.win = next_s.st == S_WINDOW;
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.rst_pin <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  fes_bus u_bus (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n),
    .abort_i (hw_reset_i),
    .start_i (s.bus_start),
    .cyc_i   (s.cyc),
    .dq_i    (s.dq_s2),
    .pins_o  (fl_o),
    .done_o  (bus_done),
    .rdata_o (bus_rdata)
  );

  assign fl_reset_n_o    = s.rst_pin;
  assign cmd_ready_o     = s.rdy;
  assign cmd_done_o      = s.done;
  assign cmd_refused_o   = s.refused;
  assign rdata_o         = s.rdata;
  assign status_o        = s.status;
  assign dev_ready_o     = s.rb_s2;
  assign window_open_o   = s.win;
  assign suspended_o     = s.susp;
  assign erase_aborted_o = s.aborted;
  assign pw_portions_o   = s.pw_done;

  // Counts write strobes of the current command for the checks below.
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_cnt <= 3'h0;
    end else if (acc) begin
      wr_cnt <= 3'h0;
    end else if (bus_done && s.cyc.wr) begin
      wr_cnt <= wr_cnt + 3'h1;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n);

  property p_chip_six;
    (s.st == S_WAIT && bus_done && s.op == OP_CHIP && s.step == LAST_LONG && !hw_reset_i)
      |=> (wr_cnt == 3'h6 && s.st == S_POLL_REQ);
  endproperty
  a_chip_six: assert property (p_chip_six) else $error("chip erase not six writes");

  property p_sect_six;
    (s.st == S_WAIT && bus_done && s.op == OP_SECT && s.step == LAST_LONG && !hw_reset_i)
      |=> (wr_cnt == 3'h6 && s.st == S_WINDOW && s.cnt == 12'h000);
  endproperty
  a_sect_six: assert property (p_sect_six) else $error("sector erase not six writes");

  property p_add_in_window;
    (acc && cmd_op_i == OP_ADD) |-> (s.st == S_WINDOW && s.cnt < WIN_LIM);
  endproperty
  a_add_in_window: assert property (p_add_in_window) else $error("late sector write");

  property p_window_close;
    (s.st == S_WINDOW && s.cnt == WIN_LIM && !acc && !hw_reset_i) |=> s.st == S_POLL_REQ;
  endproperty
  a_window_close: assert property (p_window_close) else $error("window overran");

  property p_susp_sector_only;
    (s.bus_start && s.cyc.wr && s.op == OP_SUSP) |-> (s.sect && s.cyc.data == SUSP_CODE);
  endproperty
  a_susp_sector_only: assert property (p_susp_sector_only) else $error("bad suspend");

  property p_susp_wait;
    (s.st == S_WAIT && bus_done && s.op == OP_SUSP && !hw_reset_i)
      |=> !s.susp [*8] ##[1:800] (s.susp && s.done);
  endproperty
  a_susp_wait: assert property (p_susp_wait) else $error("suspend wait wrong");

  property p_resume_src;
    (acc && cmd_op_i == OP_RESUME) |-> (s.susp && s.st == S_SUSP);
  endproperty
  a_resume_src: assert property (p_resume_src) else $error("resume not suspended");

  property p_pw_code;
    (s.bus_start && s.op == OP_PWPROG && s.step == 3'h2)
      |-> (s.cyc.wr && s.cyc.data == PW_PROG_CODE && s.cyc.addr == UNL1_ADDR);
  endproperty
  a_pw_code: assert property (p_pw_code) else $error("password code wrong");

  property p_abort_flag;
    (hw_reset_i && s.st inside {S_WINDOW, S_POLL_WAIT, S_SUSP})
      |=> (s.aborted && !fl_reset_n_o && !s.rdy);
  endproperty
  a_abort_flag: assert property (p_abort_flag) else $error("abort not flagged");

  property p_poll_done;
    (s.st == S_POLL_WAIT && bus_done && s.have && bus_rdata[TOG_BIT] == s.tog
     && s.op inside {OP_CHIP, OP_SECT, OP_ADD, OP_RESUME} && !hw_reset_i)
      |=> (s.done && s.st == S_IDLE);
  endproperty
  a_poll_done: assert property (p_poll_done) else $error("poll finish missed");

  c_chip_done: cover property (s.done && s.op == OP_CHIP);
  c_add_taken: cover property (acc && cmd_op_i == OP_ADD);
  c_suspend_resume: cover property (acc && cmd_op_i == OP_RESUME);
  c_pw_all: cover property (s.pw_done == 4'hf);

endmodule
`default_nettype wire

// *** fes_pkg.sv ***
`default_nettype none
package fes_pkg;

  localparam int AW = 23;
  localparam int DW = 16;

  // Clock rate and the derived cycle counts.
  localparam int CLK_MHZ = 40;
  localparam int CLK_NS  = 25;

  localparam int WIN_US    = 50;
  localparam int WIN_CYC   = WIN_US * CLK_MHZ;
  // Margin so that a queued sector write lands well inside the window.
  localparam int WIN_GUARD = 16;
  localparam logic [11:0] WIN_LIM  = 12'(WIN_CYC - WIN_GUARD);

  localparam int SUSP_US = 20;
  localparam logic [11:0] SUSP_CYC = 12'(SUSP_US * CLK_MHZ);

  localparam int RP_NS = 500;
  localparam logic [11:0] RP_CYC   = 12'((RP_NS + CLK_NS - 1) / CLK_NS);

  localparam int WP_NS    = 35;
  localparam int ACC_NS   = 70;
  localparam int SYNC_LAT = 2;
  localparam logic [3:0] WP_CYC  = 4'((WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] ACC_CYC = 4'((ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_LAT);

  // Status bit positions of a word read from a busy bank.
  localparam int TIMER_BIT = 3;
  localparam int TOG2_BIT  = 2;
  localparam int TOG_BIT   = 6;
  localparam int POLL_BIT  = 7;

  // Command addresses and codes, kept here so they can be retuned per part.
  localparam logic [AW-1:0] UNL1_ADDR = 23'h000555;
  localparam logic [AW-1:0] UNL2_ADDR = 23'h0002aa;
  localparam logic [DW-1:0] UNL1_DATA = 16'h00aa;
  localparam logic [DW-1:0] UNL2_DATA = 16'h0055;
  localparam logic [DW-1:0] SETUP_CODE  = 16'h0080;
  localparam logic [DW-1:0] CHIP_CODE   = 16'h0010;
  localparam logic [DW-1:0] SECT_CODE   = 16'h0030;
  localparam logic [DW-1:0] SUSP_CODE   = 16'h00b0;
  localparam logic [DW-1:0] RESUME_CODE = 16'h0030;
  localparam logic [DW-1:0] RESET_CODE  = 16'h00f0;
  localparam logic [DW-1:0] PW_PROG_CODE = 16'h0038;
  localparam logic [DW-1:0] PW_VER_CODE  = 16'h00c8;

  localparam logic [2:0] LAST_LONG = 3'h5;
  localparam logic [2:0] LAST_PW   = 3'h3;
  localparam logic [2:0] LAST_ONE  = 3'h0;

  typedef enum logic [3:0] {
    OP_READ, OP_CHIP, OP_SECT, OP_ADD, OP_SUSP,
    OP_RESUME, OP_RESET, OP_PWPROG, OP_PWVER
  } fes_op_t;

  typedef struct packed {
    logic            wr;
    logic [AW-1:0]   addr;
    logic [DW-1:0]   data;
  } fes_cyc_t;

  typedef struct packed {
    logic [AW-1:0]   addr;
    logic [DW-1:0]   dq;
    logic            dq_oe_n;
    logic            we_n;
    logic            oe_n;
    logic            ce_n;
  } fes_pins_t;

endpackage
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fes_pkg::*;
  logic          mclk = 1'b0, rst_n = 1'b0, valid = 1'b0, hw_reset = 1'b0;
  fes_op_t       op = OP_READ;
  logic [AW-1:0] addr = '0;
  logic [DW-1:0] data = '0, dq, rdata, status;
  fes_pins_t     fl;
  logic          rb_n, fl_reset_n, ready, done, refused, dev_ready, win, susp, aborted;
  logic [3:0]    portions;
  logic [1:0]    r;
  int            errors = 0, compares = 0, cyc = 0, n0;
  fes_host_seq dut (.mclk_i(mclk), .rst_n_i(rst_n), .cmd_valid_i(valid), .cmd_op_i(op),
    .cmd_addr_i(addr), .cmd_data_i(data), .hw_reset_i(hw_reset), .fl_dq_i(dq),
    .fl_ready_busy_n_i(rb_n), .fl_o(fl), .fl_reset_n_o(fl_reset_n), .cmd_ready_o(ready),
    .cmd_done_o(done), .cmd_refused_o(refused), .rdata_o(rdata), .status_o(status),
    .dev_ready_o(dev_ready), .window_open_o(win), .suspended_o(susp),
    .erase_aborted_o(aborted), .pw_portions_o(portions));
  fes_flash_mdl mdl (.mclk_i(mclk), .rst_n_i(fl_reset_n), .pins_i(fl), .dq_o(dq),
    .ready_busy_n_o(rb_n));
  initial begin
    forever #12.5 mclk = !mclk;
  end
  task automatic close_out;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Done and refused stand one cycle, so every cycle is looked at.
  task automatic wdone(input int lim);
    r = 2'b00;
    #1;
    for (int i = 0; i < lim; i++) begin
      r = {refused === 1'b1, done === 1'b1};
      if (r != 2'b00) break;
      @(posedge mclk);
      #1;
    end
  endtask
  task automatic cmd(input fes_op_t o, input logic [AW-1:0] ad, input logic [DW-1:0] dt,
                     input int lim);
    @(posedge mclk);
    valid <= 1'b1;
    op    <= o;
    addr  <= ad;
    data  <= dt;
    #1;
    // The request stands until an edge at which ready is seen high, so none is lost.
    for (int i = 0; i < 9000 && ready !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    @(posedge mclk);
    valid <= 1'b0;
    wdone(lim);
  endtask
  task automatic t_refuse;
    fes_op_t bad [3] = '{OP_ADD, OP_SUSP, OP_RESUME};
    foreach (bad[k]) begin
      cmd(bad[k], 23'h000000, 16'h0000, 4);
      chk(16'(r), 16'h0002);
    end
  endtask
  task automatic t_sect;
    n0 = mdl.nw;
    cmd(OP_SECT, 23'h018000, 16'h0000, 100);
    chk(16'(mdl.nw - n0), 16'h0006);
    chk(16'(win), 16'h0001);
    cmd(OP_ADD, 23'h038000, 16'h0000, 100);
    chk(16'(mdl.sel[7] & mdl.sel[3]), 16'h0001);
    wdone(8000);
    chk(16'(r), 16'h0001);
    chk(status, 16'hffff);
    cmd(OP_READ, 23'h038000, 16'h0000, 40);
    chk(rdata, 16'hffff);
    cmd(OP_READ, 23'h048000, 16'h0000, 40);
    chk(rdata, 16'hbc3c);
  endtask
  task automatic t_susp;
    cmd(OP_SECT, 23'h028000, 16'h0000, 100);
    cmd(OP_SUSP, 23'h000000, 16'h0000, 1000);
    chk(16'({r, susp}), 16'h0003);
    cmd(OP_READ, 23'h028000, 16'h0000, 40);
    chk(rdata & 16'hfffb, 16'h0080);
    cmd(OP_READ, 23'h048000, 16'h0000, 40);
    chk(rdata, 16'hbc3c);
    cmd(OP_RESUME, 23'h028000, 16'h0000, 3000);
    chk(16'({r, susp}), 16'h0002);
  endtask
  task automatic t_chip;
    n0 = mdl.nw;
    cmd(OP_CHIP, 23'h000000, 16'h0000, 100);
    chk(16'(mdl.nw - n0), 16'h0006);
    chk(16'(dev_ready), 16'h0000);
    hw_reset <= 1'b1;
    repeat (4) @(posedge mclk);
    hw_reset <= 1'b0;
    #1;
    chk(16'({fl_reset_n, rb_n, ready}), 16'h0002);
    cmd(OP_READ, 23'h048000, 16'h0000, 40);
    chk({rdata[14:0], aborted}, 16'h7879);
    cmd(OP_CHIP, 23'h000000, 16'h0000, 3000);
    chk(16'({r, aborted}), 16'h0002);
    cmd(OP_READ, 23'h048000, 16'h0000, 40);
    chk(rdata, 16'hffff);
  endtask
  task automatic t_pw;
    for (int k = 0; k < 4; k++) begin
      cmd(OP_PWPROG, 23'(3 - k), 16'h5a00 | 16'(3 - k), 500);
      chk(16'(r), 16'h0001);
    end
    chk(16'(portions), 16'h000f);
    cmd(OP_PWPROG, 23'h000002, 16'hffff, 500);
    for (int k = 0; k < 4; k++) begin
      cmd(OP_PWVER, 23'h600000 | 23'(k), 16'h0000, 100);
      chk(rdata, 16'h5a00 | 16'(k));
    end
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk(16'({fl_reset_n, win, susp, aborted, portions}), 16'h0080);
    t_refuse;
    t_sect;
    t_susp;
    t_chip;
    t_pw;
    close_out;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      close_out;
    end
  end
endmodule
`default_nettype wire
